/* File: logic/iea_pkg.sv */
// Constants for the interrupt enable, latch and acceptance block.
// Assumes an 8-bit SFR port and a CPU core that sequences instructions.
`default_nettype none
package iea_pkg;
	// SFR addresses of the enable registers and request latches
	localparam logic [7:0] ADDR_ENABLE_EXT = 8'h2C;
	localparam logic [7:0] ADDR_LATCH_EXT = 8'h2E;
	localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
	localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
	localparam logic [7:0] ADDR_LATCH_LOW = 8'h3C;
	localparam logic [7:0] ADDR_LATCH_HIGH = 8'h3D;

	// Field layout
	localparam int NUM_SRC = 24;
	localparam int FIRST_SRC = 2;
	localparam int FIRST_MASKABLE = 4;
	localparam int MASTER_ENABLE_BIT = 0;
	localparam logic [23:0] NONMASKABLE_SET = 24'h00000C;
	localparam logic [23:0] MASKABLE_SET = 24'hFFFFF0;
	localparam logic [23:0] LATCH_RESET = 24'h000000;
	localparam logic [23:0] ENABLE_RESET = 24'h000000;
	localparam logic MASTER_RESET = 1'h0;

	// Status word bit that carries the master enable when stacked
	localparam int STATUS_IMF_BIT = 0;

	// Vector table: sources 2..15 count down from the first base,
	// sources 16..23 from the second
	localparam logic [15:0] VEC_BASE_LOW = 16'hFFFA;
	localparam logic [15:0] VEC_BASE_EXT = 16'hFFBE;
	localparam logic [4:0] SRC_EXT_FIRST = 5'h10;
	localparam logic [4:0] SRC_LOW_FIRST = 5'h02;

	// Acceptance timing
	localparam int ACCEPT_MCYCLES = 8;
	localparam int MCYCLE_CLKS = 4;
	localparam int MAX_LATENCY_CLKS = 38;
	localparam logic [2:0] MC_SAVE = 3'h0;
	localparam logic [2:0] MC_PUSH_STATUS = 3'h1;
	localparam logic [2:0] MC_PUSH_PCH = 3'h2;
	localparam logic [2:0] MC_PUSH_PCL = 3'h3;
	localparam logic [2:0] MC_VECTOR = 3'h4;
	localparam logic [2:0] MC_LOAD = 3'h7;

	typedef enum logic [0:0] {
		IEA_IDLE,
		IEA_ACCEPT
	} iea_state_t;
endpackage : iea_pkg
`default_nettype wire

/* File: logic/iea_prio.sv */
// Fixed priority pick among eligible request latches.
// Assumes the caller has already applied the enable masks.
`timescale 1ns/1ps
`default_nettype none
module iea_prio #(
	parameter int NSRC = 24,
	parameter int FIRST = 2
) (
	// Eligible requests
	input wire logic [NSRC-1:0] eligible,
	// Winner
	output logic found,
	output logic [4:0] winner
);
	// Lower index wins; of the two non-maskable latches, the lower is taken first
	always_comb begin
		found = 1'b0;
		winner = 5'h00;
		for (int i = NSRC - 1; i >= FIRST; i--) begin
			if (eligible[i]) begin
				found = 1'b1;
				winner = 5'(i);
			end
		end
	end
endmodule : iea_prio
`default_nettype wire

/* File: logic/iea_ctrl.sv */
// Interrupt enable flags, request latches and 8 machine cycle acceptance.
// Assumes a CPU core that marks the final cycle of each instruction,
// writes the stack from push strobes and reports return instructions.
//
// Operation
// [RULE_01] Non-maskable sources ignore all enable flags
// [RULE_02] Master enable 0 blocks every maskable source
// [RULE_03] Stack master enable, then clear it
// [RULE_04] Either return reloads master enable from stack
// [RULE_05] Master enable is bit 0 at 3AH, resets 0
// [RULE_06] Source enable 1 allows, 0 blocks; reset 0
// [RULE_07] Enable registers read and write normally
// [RULE_08] Latch reads pending; write 0 clears, 1 keeps
// [RULE_09] Software writes 1 to latches 2,3 when clearing
// [RULE_10] Software disables master enable around mask edits
// [RULE_11] Software never sets master and flags together
// [RULE_12] Software clears latches by whole-register loads
// [RULE_13] Latch holds until accepted, reset or cleared
// [RULE_14] Acceptance follows instruction end, 8 machine cycles
// [RULE_15] Maskable ends with maskable return, else nonmaskable
// [RULE_16] Acceptance clears the accepted latch
// [RULE_17] Push status, PC high, PC low; SP minus 3
// [RULE_18] Load PC from the source's vector slot
// [RULE_19] Acceptance starts within 38 clocks of latch set
// [RULE_20] Master enable 0 blocks even higher priority
// [RULE_21] Only PC and status word are stacked
// [RULE_22] Software clears own enable before nesting
// [RULE_23] Source request sets its latch; reset clears all
// [RULE_24] Simultaneous requests taken in fixed priority
// [RULE_25] Return restores PC, status; SP plus 3 (the block pulses sp_inc only once per return)
// [RULE_26] Request CPU when an eligible latch is set
`timescale 1ns/1ps
`default_nettype none
module iea_ctrl #(
	parameter int NSRC = iea_pkg::NUM_SRC,
	parameter int MC_CLKS = iea_pkg::MCYCLE_CLKS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// SFR port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Interrupt sources, one-cycle request pulses, index 2..23
	input wire logic [NSRC-1:0] src_req,
	// CPU instruction stream
	input wire logic instr_last,
	input wire logic [15:0] cpu_pc,
	input wire logic [7:0] cpu_status,
	input wire logic ret_strobe,
	input wire logic ret_nonmask,
	input wire logic [7:0] ret_status,
	input wire logic [15:0] vec_data,
	// Requests and acceptance outputs
	output logic irq_request,
	output logic accept_busy,
	output logic [4:0] accept_src,
	output logic stack_wr,
	output logic [7:0] stack_data,
	output logic sp_dec,
	output logic sp_inc,
	output logic vec_rd,
	output logic [15:0] vec_addr,
	output logic pc_load,
	output logic [15:0] pc_value
);
	// Reset release through two flops; async assert, clocked release
	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	function automatic logic [15:0] vector_of(input logic [4:0] src);
		logic [15:0] off;
		off = 16'h0000;
		if (src >= iea_pkg::SRC_EXT_FIRST) begin
			off = {10'h000, src - iea_pkg::SRC_EXT_FIRST, 1'b0};
			vector_of = iea_pkg::VEC_BASE_EXT - off;
		end else begin
			off = {10'h000, src - iea_pkg::SRC_LOW_FIRST, 1'b0};
			vector_of = iea_pkg::VEC_BASE_LOW - off;
		end
	endfunction : vector_of

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// Register state
	logic [NSRC-1:0] latch;
	logic [NSRC-1:0] next_latch;
	logic [NSRC-1:0] enable;
	logic [NSRC-1:0] next_enable;
	logic master;
	logic next_master;
	logic [7:0] next_sfr_rdata;

	// Acceptance state
	iea_pkg::iea_state_t state;
	iea_pkg::iea_state_t next_state;
	logic [2:0] mc;
	logic [2:0] next_mc;
	logic [1:0] ck;
	logic [1:0] next_ck;
	logic [7:0] saved_status;
	logic [7:0] next_saved_status;
	logic [15:0] saved_pc;
	logic [15:0] next_saved_pc;
	logic [4:0] next_accept_src;
	logic next_irq_request;
	logic next_accept_busy;
	logic next_stack_wr;
	logic [7:0] next_stack_data;
	logic next_sp_dec;
	logic next_sp_inc;
	logic next_vec_rd;
	logic [15:0] next_vec_addr;
	logic next_pc_load;
	logic [15:0] next_pc_value;

	// Eligibility and priority
	logic [NSRC-1:0] eligible;
	logic win_found;
	logic [4:0] win_src;
	logic mc_start;
	logic mc_end;

	always_comb begin
		eligible = latch & (iea_pkg::NONMASKABLE_SET[NSRC-1:0] // RULE_01
			| (enable & iea_pkg::MASKABLE_SET[NSRC-1:0] & {NSRC{master}})); // RULE_02 RULE_20
	end

	iea_prio #(
		.NSRC(NSRC),
		.FIRST(iea_pkg::FIRST_SRC)
	) u_prio (
		.eligible(eligible),
		.found(win_found),
		.winner(win_src)
	);

	assign mc_start = (ck == 2'h0);
	assign mc_end = (ck == 2'(MC_CLKS - 1));

	// Register file and latches
	always_comb begin
		next_latch = latch;
		next_enable = enable;
		next_master = master;
		next_sfr_rdata = sfr_rdata;
		// Write 0 clears, write 1 never sets
		if (sfr_wr) begin
			if (hit(sfr_addr, iea_pkg::ADDR_LATCH_LOW)) begin
				next_latch[7:2] = latch[7:2] & sfr_wdata[7:2]; // RULE_08
			end
			if (hit(sfr_addr, iea_pkg::ADDR_LATCH_HIGH)) begin
				next_latch[15:8] = latch[15:8] & sfr_wdata; // RULE_08
			end
			if (hit(sfr_addr, iea_pkg::ADDR_LATCH_EXT)) begin
				next_latch[23:16] = latch[23:16] & sfr_wdata; // RULE_08
			end
			if (hit(sfr_addr, iea_pkg::ADDR_ENABLE_LOW)) begin
				next_enable[7:4] = sfr_wdata[7:4]; // RULE_07
				next_master = sfr_wdata[iea_pkg::MASTER_ENABLE_BIT]; // RULE_05
			end
			if (hit(sfr_addr, iea_pkg::ADDR_ENABLE_HIGH)) begin
				next_enable[15:8] = sfr_wdata; // RULE_07
			end
			if (hit(sfr_addr, iea_pkg::ADDR_ENABLE_EXT)) begin
				next_enable[23:16] = sfr_wdata; // RULE_07
			end
		end
		// Return reloads the stacked master enable
		if (ret_strobe) begin // RULE_15
			next_master = ret_status[iea_pkg::STATUS_IMF_BIT]; // RULE_04
		end
		// Acceptance clears master enable and the winning latch
		if (state == iea_pkg::IEA_ACCEPT && mc == iea_pkg::MC_SAVE && mc_start) begin
			next_master = 1'b0; // RULE_03
			next_latch[accept_src] = 1'b0; // RULE_16
		end
		// New requests last, so a set beats any clear in the same cycle
		next_latch = next_latch | src_req; // RULE_23
		next_latch[1:0] = 2'h0;
		next_enable[3:0] = 4'h0;
		if (sfr_rd) begin
			case (sfr_addr)
				iea_pkg::ADDR_LATCH_LOW: next_sfr_rdata = {latch[7:2], 2'h0}; // RULE_08
				iea_pkg::ADDR_LATCH_HIGH: next_sfr_rdata = latch[15:8];
				iea_pkg::ADDR_LATCH_EXT: next_sfr_rdata = latch[23:16];
				iea_pkg::ADDR_ENABLE_LOW: next_sfr_rdata = {enable[7:4], 3'h0, master}; // RULE_05
				iea_pkg::ADDR_ENABLE_HIGH: next_sfr_rdata = enable[15:8];
				iea_pkg::ADDR_ENABLE_EXT: next_sfr_rdata = enable[23:16];
				default: next_sfr_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			latch <= iea_pkg::LATCH_RESET[NSRC-1:0]; // RULE_23
			enable <= iea_pkg::ENABLE_RESET[NSRC-1:0]; // RULE_06
			master <= iea_pkg::MASTER_RESET; // RULE_05
			sfr_rdata <= 8'h00;
		end else begin
			latch <= next_latch; // RULE_13
			enable <= next_enable;
			master <= next_master;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// Acceptance sequencer
	always_comb begin
		next_state = state;
		next_mc = mc;
		next_ck = ck;
		next_saved_status = saved_status;
		next_saved_pc = saved_pc;
		next_accept_src = accept_src;
		next_accept_busy = accept_busy;
		next_stack_wr = 1'b0;
		next_stack_data = stack_data;
		next_sp_dec = 1'b0;
		next_sp_inc = ret_strobe; // RULE_25
		next_vec_rd = 1'b0;
		next_vec_addr = vec_addr;
		next_pc_load = 1'b0;
		next_pc_value = pc_value;
		// Idle request only; the request is dropped while busy
		next_irq_request = win_found && (state == iea_pkg::IEA_IDLE); // RULE_26
		case (state)
			iea_pkg::IEA_IDLE: begin
				next_ck = 2'h0;
				next_mc = 3'h0;
				// Sampled only at the instruction's final cycle
				if (instr_last && win_found) begin // RULE_14 RULE_19
					next_state = iea_pkg::IEA_ACCEPT;
					next_accept_src = win_src; // RULE_24
					next_accept_busy = 1'b1;
					next_saved_pc = cpu_pc; // RULE_21
					next_irq_request = 1'b0;
				end
			end
			iea_pkg::IEA_ACCEPT: begin
				next_ck = mc_end ? 2'h0 : ck + 2'h1;
				if (mc_end) begin
					next_mc = mc + 3'h1;
				end
				if (mc_start) begin
					case (mc)
						iea_pkg::MC_SAVE: begin
							// Capture old master enable before its clear lands
							next_saved_status = cpu_status;
							next_saved_status[iea_pkg::STATUS_IMF_BIT] = master; // RULE_03
						end
						iea_pkg::MC_PUSH_STATUS: begin
							next_stack_wr = 1'b1; // RULE_17
							next_stack_data = saved_status;
							next_sp_dec = 1'b1;
						end
						iea_pkg::MC_PUSH_PCH: begin
							next_stack_wr = 1'b1; // RULE_17
							next_stack_data = saved_pc[15:8];
							next_sp_dec = 1'b1;
						end
						iea_pkg::MC_PUSH_PCL: begin
							next_stack_wr = 1'b1; // RULE_17
							next_stack_data = saved_pc[7:0];
							next_sp_dec = 1'b1;
						end
						iea_pkg::MC_VECTOR: begin
							next_vec_rd = 1'b1; // RULE_18
							next_vec_addr = vector_of(accept_src);
						end
						default: begin
							next_stack_wr = 1'b0;
						end
					endcase
				end
				// Last clock of the eighth machine cycle hands over the entry
				if (mc == iea_pkg::MC_LOAD && mc_end) begin // RULE_14
					next_pc_load = 1'b1; // RULE_18
					next_pc_value = vec_data;
					next_state = iea_pkg::IEA_IDLE;
					next_accept_busy = 1'b0;
				end
			end
			default: begin
				next_state = iea_pkg::IEA_IDLE;
				next_accept_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= iea_pkg::IEA_IDLE;
			mc <= 3'h0;
			ck <= 2'h0;
			saved_status <= 8'h00;
			saved_pc <= 16'h0000;
			accept_src <= 5'h00;
			accept_busy <= 1'b0;
			irq_request <= 1'b0;
			stack_wr <= 1'b0;
			stack_data <= 8'h00;
			sp_dec <= 1'b0;
			sp_inc <= 1'b0;
			vec_rd <= 1'b0;
			vec_addr <= 16'h0000;
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
		end else begin
			state <= next_state;
			mc <= next_mc;
			ck <= next_ck;
			saved_status <= next_saved_status;
			saved_pc <= next_saved_pc;
			accept_src <= next_accept_src;
			accept_busy <= next_accept_busy;
			irq_request <= next_irq_request;
			stack_wr <= next_stack_wr;
			stack_data <= next_stack_data;
			sp_dec <= next_sp_dec;
			sp_inc <= next_sp_inc;
			vec_rd <= next_vec_rd;
			vec_addr <= next_vec_addr;
			pc_load <= next_pc_load;
			pc_value <= next_pc_value;
		end
	end
endmodule : iea_ctrl
`default_nettype wire

/* File: bench/iea_ctrl_assertions.sv */
// Checker on the acceptance block ports: sequencing, stacking, vectors.
// Assumes the default machine cycle of four clocks.
`timescale 1ns/1ps
`default_nettype none
module iea_ctrl_assertions #(
	parameter int NSRC = 24,
	parameter int MC_CLKS = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Inputs watched
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_rd,
	input wire logic instr_last,
	input wire logic [15:0] cpu_pc,
	input wire logic ret_strobe,
	input wire logic [15:0] vec_data,
	// Outputs watched
	input wire logic [7:0] sfr_rdata,
	input wire logic irq_request,
	input wire logic accept_busy,
	input wire logic [4:0] accept_src,
	input wire logic stack_wr,
	input wire logic [7:0] stack_data,
	input wire logic sp_dec,
	input wire logic sp_inc,
	input wire logic vec_rd,
	input wire logic [15:0] vec_addr,
	input wire logic pc_load,
	input wire logic [15:0] pc_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_start;
		$rose(accept_busy);
	endsequence
	sequence s_pushes;
		##5 (stack_wr && sp_dec) ##4 stack_wr ##4 stack_wr ##4 vec_rd;
	endsequence
	property p_length;
		s_start |-> accept_busy [*8] ##24 accept_busy ##1 (!accept_busy && pc_load);
	endproperty
	a_length: assert property (p_length) else $error("acceptance length wrong");
	property p_order;
		s_start |-> s_pushes;
	endproperty
	a_order: assert property (p_order) else $error("push order wrong");
	property p_pcstack;
		s_start |-> ##9 (stack_data == 8'($past(cpu_pc, 10) >> 8)) ##4
			(stack_data == 8'($past(cpu_pc, 14)));
	endproperty
	a_pcstack: assert property (p_pcstack) else $error("stacked pc wrong");
	property p_push;
		(stack_wr || sp_dec) |-> (stack_wr && sp_dec && accept_busy);
	endproperty
	a_push: assert property (p_push) else $error("push without sp step");
	property p_take;
		s_start |-> $past(instr_last);
	endproperty
	a_take: assert property (p_take) else $error("accept mid instruction");
	property p_quiet;
		accept_busy && $past(accept_busy) |-> !irq_request;
	endproperty
	a_quiet: assert property (p_quiet) else $error("request while busy");
	property p_ret;
		ret_strobe |=> sp_inc;
	endproperty
	a_ret: assert property (p_ret) else $error("no sp step on return");
	property p_vaddr;
		vec_rd |-> vec_addr == ((accept_src < 5'h10) ? 16'hFFFE - {10'h000, accept_src, 1'b0}
			: 16'hFFDE - {10'h000, accept_src, 1'b0});
	endproperty
	a_vaddr: assert property (p_vaddr) else $error("vector slot wrong");
	property p_entry;
		pc_load |-> pc_value == $past(vec_data);
	endproperty
	a_entry: assert property (p_entry) else $error("entry address wrong");
	property p_unmapped;
		sfr_rd && sfr_addr == 8'h01 |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : iea_ctrl_assertions
bind iea_ctrl iea_ctrl_assertions #(.NSRC(NSRC), .MC_CLKS(MC_CLKS)) u_chk (.sys_clk, .rst_n,
	.sfr_addr, .sfr_rd, .instr_last, .cpu_pc, .ret_strobe, .vec_data, .sfr_rdata, .irq_request,
	.accept_busy, .accept_src, .stack_wr, .stack_data, .sp_dec, .sp_inc, .vec_rd, .vec_addr,
	.pc_load, .pc_value);
`default_nettype wire

/* File: bench/iea_cpu_model.sv */
// CPU core model: instruction ends, PC, status and vector table words.
// Assumes the table word is read only between vec_rd and pc_load.
`timescale 1ns/1ps
`default_nettype none
module iea_cpu_model (
	// Clock
	input wire logic sys_clk,
	// Block side
	input wire logic vec_rd,
	input wire logic [15:0] vec_addr,
	input wire logic pc_load,
	// Core side
	output logic instr_last,
	output logic [15:0] cpu_pc,
	output logic [7:0] cpu_status,
	output logic [15:0] vec_data
);
	logic [1:0] phase = 2'h0;
	logic hold = 1'b0;
	initial begin
		instr_last = 1'b0;
		cpu_pc = 16'h5AC3;
		cpu_status = 8'hA4;
		vec_data = 16'h0000;
	end
	// Four clock instructions; table word is its slot address inverted
	// Non-blocking on the edge, so the bench reads settled values
	always @(posedge sys_clk) begin
		phase <= phase + 2'h1;
		instr_last <= (phase == 2'h2);
		if (vec_rd) begin
			vec_data <= ~vec_addr;
			hold <= 1'b1;
		end else if (!hold) begin
			vec_data <= ~vec_data; // Idle bus must not look valid
		end
		if (pc_load) begin
			hold <= 1'b0;
		end
	end
endmodule : iea_cpu_model
`default_nettype wire

/* File: bench/iea_ctrl_tb.sv */
// Testbench for the interrupt acceptance block with a CPU core model.
// Assumes the default four clock machine cycle.
`timescale 1ns/1ps
`default_nettype none
module iea_ctrl_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [23:0] src_req = 24'h000000;
	logic ret_strobe = 1'b0;
	logic ret_nonmask = 1'b0;
	logic [7:0] ret_status = 8'h00;
	logic instr_last, irq_request, accept_busy, stack_wr, sp_dec, sp_inc, vec_rd, pc_load;
	logic [15:0] cpu_pc, vec_data, vec_addr, pc_value;
	logic [7:0] cpu_status, sfr_rdata, stack_data;
	logic [4:0] accept_src;
	logic [7:0] regs [7] = '{8'h2C, 8'h2E, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h01};
	int fail_count = 0;
	int n_compared = 0;
	iea_ctrl dut (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .src_req,
		.instr_last, .cpu_pc, .cpu_status, .ret_strobe, .ret_nonmask, .ret_status, .vec_data,
		.irq_request, .accept_busy, .accept_src, .stack_wr, .stack_data, .sp_dec, .sp_inc,
		.vec_rd, .vec_addr, .pc_load, .pc_value);
	iea_cpu_model cpu (.sys_clk, .vec_rd, .vec_addr, .pc_load, .instr_last, .cpu_pc,
		.cpu_status, .vec_data);
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		step(1);
		sfr_wr = 1'b0;
		step(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		sfr_addr = a;
		sfr_rd = 1'b1;
		step(1);
		sfr_rd = 1'b0;
		step(1);
		check(16'(sfr_rdata), 16'(want));
	endtask : rd
	// Syncs on the first push, so a take already under way is not missed
	task automatic take(input logic [4:0] s, input logic master_enable);
		int k;
		logic [15:0] va;
		k = 0;
		va = (s < 5'h10) ? 16'hFFFE - {10'h000, s, 1'b0} : 16'hFFDE - {10'h000, s, 1'b0};
		while (stack_wr !== 1'b1 && k < 45) begin
			step(1);
			k++;
		end
		if (k == 45) begin
			fail_count++;
			final_report();
		end
		check(16'(accept_src), 16'(s));
		check(16'(stack_data), {8'h00, cpu_status[7:1], master_enable});
		step(4);
		check(16'(stack_data), 16'(cpu_pc[15:8]));
		step(4);
		check(16'(stack_data), 16'(cpu_pc[7:0]));
		step(4);
		check(vec_addr, va);
		step(15);
		check(16'(pc_load), 16'h0001);
		check(pc_value, ~va);
	endtask : take
	task automatic t_mask();
		src_req = 24'h000100;
		step(1);
		src_req = 24'h000000;
		rd(8'h3D, 8'h01);
		check(16'(irq_request), 16'h0000);
		wr(8'h3D, 8'hFF);
		rd(8'h3D, 8'h01);
		wr(8'h3C, 8'h0C);
		wr(8'h3D, 8'h00);
		rd(8'h3D, 8'h00);
	endtask : t_mask
	task automatic t_accept();
		int k;
		k = 0;
		src_req = 24'h002400;
		step(1);
		src_req = 24'h000000;
		wr(8'h3A, 8'h01);
		take(5'h0A, 1'b1);
		wr(8'h3B, 8'hA1);
		rd(8'h3A, 8'h00);
		rd(8'h3D, 8'h20);
		check(16'(irq_request), 16'h0000);
		// Return in a last cycle, so the next take is a full instruction away
		while (instr_last !== 1'b1 && k < 8) begin
			step(1);
			k++;
		end
		if (k == 8) begin
			fail_count++;
			final_report();
		end
		ret_status = 8'h01;
		ret_nonmask = 1'b0;
		ret_strobe = 1'b1;
		step(1);
		ret_strobe = 1'b0;
		check(16'(sp_inc), 16'h0001);
		step(1);
		check(16'(irq_request), 16'h0001);
		take(5'h0D, 1'b1);
	endtask : t_accept
	task automatic t_nmi();
		src_req = 24'h00000C;
		step(1);
		src_req = 24'h000000;
		take(5'h02, 1'b0);
		take(5'h03, 1'b0);
	endtask : t_nmi
	// Source 16 stays blocked by its own flag; 17 takes the upper table
	task automatic t_ext();
		src_req = 24'h030000;
		step(1);
		src_req = 24'h000000;
		wr(8'h3A, 8'h01);
		take(5'h11, 1'b1);
		rd(8'h2E, 8'h01);
		wr(8'h2E, 8'h00);
		rd(8'h2E, 8'h00);
	endtask : t_ext
	task automatic t_regs();
		foreach (regs[i]) begin
			rd(regs[i], 8'h00);
		end
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h00);
		wr(8'h3A, 8'hF0);
		wr(8'h3B, 8'hA5);
		wr(8'h2C, 8'h5A);
		rd(8'h3A, 8'hF0);
		rd(8'h3B, 8'hA5);
		rd(8'h2C, 8'h5A);
		wr(8'h3A, 8'h01);
		rd(8'h3A, 8'h01);
		wr(8'h3A, 8'h00);
	endtask : t_regs
	initial begin
		step(4);
		rst_n = 1'b1;
		step(3);
		t_regs();
		t_mask();
		t_accept();
		t_nmi();
		t_ext();
		final_report();
	end
endmodule : iea_ctrl_tb
`default_nettype wire
